// ---- inc/cba_pkg.sv ----
// package: offsets, field positions, constants and states of the CAN boot autobaud block
package cba_pkg;
	// register byte offsets on the APB
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_COUNT  = 12'h008;
	localparam logic [11:0] OFS_TIMING = 12'h00C;
	localparam logic [11:0] OFS_LOAD   = 12'h010;
	localparam logic [11:0] OFS_ACKDAT = 12'h014;
	localparam logic [11:0] OFS_MEM    = 12'h200; // 128 words, one loaded byte each
	// control register fields and reset value
	localparam int          CTRL_ARM     = 0;
	localparam int          CTRL_HOLD    = 1;
	localparam int          CTRL_RESTART = 2;
	localparam logic [1:0]  CTRL_RST     = 2'h1;
	// status register fields
	localparam int          STS_CONF     = 4;
	localparam int          STS_ACK      = 5;
	localparam int          STS_FAULT    = 8;
	localparam int          STS_BOOT     = 9;
	// timing register fields
	localparam int          TIM_SJW      = 6;
	localparam int          TIM_SEGMENT_BEFORE_SAMPLE    = 8;
	localparam int          TIM_SEGMENT_AFTER_SAMPLE    = 16;
	localparam int          TIM_QUANTA   = 24;
	// zero frame measurement
	localparam logic [2:0]  STUFF_RISES  = 3'h5;  // stuff bits closing the measured span
	localparam int          FRAME_BITS   = 29;    // 25 dominant plus 4 recessive bits
	localparam int          PT_SCALE     = 2 * FRAME_BITS;
	localparam int          ERR_TICKS    = 6;     // tolerated detection uncertainty
	localparam int          BRP_STEP     = 1451;
	localparam logic [5:0]  BRP_MAX      = 6'h3F;
	localparam logic [4:0]  TQ_MIN       = 5'h08;
	localparam logic [4:0]  TQ_MAX       = 5'h19;
	localparam logic [1:0]  SJW_TQ       = 2'h2;
	// message objects
	localparam logic [10:0] ACK_ID       = 11'h0E6;
	localparam logic [3:0]  ACK_DLC      = 4'h3;
	localparam logic [10:0] BOOT_ID      = 11'h005;
	localparam logic [10:0] BOOT_MASK    = 11'h7FF;
	localparam logic [7:0]  LOAD_BYTES   = 8'h80;
	localparam int          FIFO_DEPTH   = 8;
	// sequencer states
	typedef enum logic [3:0] {
		ST_WATCH  = 4'b0000,
		ST_UART   = 4'b0001,
		ST_HALT   = 4'b0010,
		ST_CAN    = 4'b0011,
		ST_BRP    = 4'b0100,
		ST_QUANTA = 4'b0101,
		ST_CHECK  = 4'b0110,
		ST_LOAD   = 4'b0111,
		ST_DONE   = 4'b1000
	} cba_state_e;
endpackage : cba_pkg

// ---- rtl/cba_mem.sv ----
// module: byte store for the loaded boot image, registered read port
`timescale 1ns/10ps
module cba_mem #(
	parameter int AW = 7,
	parameter int DW = 8
)(
	input  wire logic          clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);
	logic [DW-1:0] cells [2**AW]; // no reset: contents only valid once written

	////////////////////////////////////////////////////////////////////////////
	// write port, fed by the fifo drain
	always_ff @(posedge clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	// read port, data one cycle after the address
	always_ff @(posedge clk) begin
		rd_data <= cells[rd_addr];
	end
endmodule : cba_mem

// ---- rtl/cba_fifo.sv ----
// module: small fifo with valid and ready on both sides
`timescale 1ns/10ps
module cba_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH); // depth must be a power of two

	logic [WIDTH-1:0] store [DEPTH]; // data slots
	logic [PW-1:0]    wr_ptr;        // next slot to fill
	logic [PW-1:0]    rd_ptr;        // oldest slot
	logic [PW:0]      count;         // words held
	logic [PW:0]      next_count;
	logic             push;
	logic             pop;

	assign push       = in_valid & in_ready;
	assign pop        = out_valid & out_ready;
	assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);
	assign out_data   = store[rd_ptr];

	////////////////////////////////////////////////////////////////////////////
	// slot writes
	always_ff @(posedge clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	// pointers, fill level and registered flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			wr_ptr    <= wr_ptr + PW'(push);
			rd_ptr    <= rd_ptr + PW'(pop);
			count     <= next_count;
			in_ready  <= next_count != (PW+1)'(DEPTH); // full stalls the source
			out_valid <= next_count != '0;
		end
	end

	chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
		count <= (PW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule : cba_fifo

// ---- rtl/cba_autobaud.sv ----
// module: CAN boot autobaud detection, controller setup and boot byte loading
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
module cba_autobaud
	import cba_pkg::*;
#(
	parameter int          CNT_W      = 16,
	parameter logic [7:0]  ACK_BYTE0  = 8'hA5,    // arbitrary acknowledge marker
	parameter logic [15:0] CHIP_IDENT = 16'h1234  // arbitrary identity value
)(
	input  wire logic        CLK_SYS,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        BOOT_LOADER_MODE,
	input  wire logic        UART_RECEIVE_LINE,
	input  wire logic        CAN_RECEIVE_PIN,
	output logic             CAN_TRANSMIT_PIN_O,
	output logic             CAN_TRANSMIT_PIN_OE_N,
	input  wire logic        CTRL_TXD,
	input  wire logic        MSG_VALID,
	output logic             MSG_READY,
	input  wire logic [10:0] MSG_ID,
	input  wire logic        MSG_REMOTE,
	input  wire logic [7:0]  MSG_BYTE,
	output logic             ACK_SEND,
	output logic      [10:0] ACK_ID_OUT,
	output logic      [3:0]  ACK_DLC_OUT,
	output logic      [23:0] ACK_DATA,
	output logic             CAN_CONFIGURED,
	output logic      [5:0]  BAUD_PRESCALER,
	output logic      [4:0]  SEGMENT_BEFORE_SAMPLE,
	output logic      [3:0]  SEGMENT_AFTER_SAMPLE,
	output logic      [1:0]  JUMP_WIDTH
);
	// quanta divisor for a given prescaler
	function automatic logic [CNT_W-1:0] tq_divisor(input logic [5:0] b);
		tq_divisor = CNT_W'(PT_SCALE * (int'(b) + 1));
	endfunction : tq_divisor

	// segment after the sample point: ceil(q/5) keeps the sample at 70-80%
	function automatic logic [3:0] seg_after(input logic [4:0] q);
		seg_after = 4'((int'(q) + 4) / 5);
	endfunction : seg_after

	cba_state_e       state;      // sequencer
	logic             boot_seen;  // strap already caught
	logic             boot_en;    // strap value: boot loader mode
	logic             can_q;      // previous CAN line sample
	logic [2:0]       rises;      // stuff bits seen so far
	logic [CNT_W-1:0] run_count;  // cycle counter of the measured span
	logic [CNT_W-1:0] count_capt; // captured span
	logic [CNT_W-1:0] rem;        // running remainder of the divisions
	logic [CNT_W-1:0] divisor;    // 58 x (prescaler + 1)
	logic [5:0]       baud_prescaler;        // prescaler being derived
	logic [4:0]       quanta;     // quanta per bit being derived
	logic [1:0]       ctrl;       // arm and hold bits
	logic             fault;      // sticky: measurement discarded
	logic             ack_sent;   // acknowledge already given
	logic [7:0]       load_count; // bytes stored
	logic             can_rise;
	logic             q_ok;
	logic             fault_set;
	logic             restart;
	logic             apb_wr;
	logic             apb_acc;
	logic             rd_hit;
	logic [31:0]      rd_val;
	logic             boot_hit;
	logic             fifo_in_valid;
	logic             fifo_out_valid;
	logic             drain;
	logic [7:0]       fifo_data;
	logic [7:0]       mem_rdata;

	assign can_rise = CAN_RECEIVE_PIN & ~can_q;
	assign divisor  = tq_divisor(baud_prescaler);
	assign q_ok     = quanta >= TQ_MIN && quanta <= TQ_MAX;
	assign apb_acc  = PSEL & PENABLE & ~PREADY;
	assign apb_wr   = PSEL & PENABLE & PREADY & PWRITE;
	assign restart  = apb_wr && PADDR == OFS_CTRL && PWDATA[CTRL_RESTART];

	// discard conditions: counter overflow, prescaler or quanta out of range
	assign fault_set = ((state == ST_CAN || state == ST_UART) && (&run_count))
		|| (state == ST_BRP && rem >= CNT_W'(BRP_STEP) && baud_prescaler == BRP_MAX)
		|| (state == ST_QUANTA && rem >= divisor && (&quanta))
		|| (state == ST_CHECK && !q_ok);

	////////////////////////////////////////////////////////////////////////////
	// strap caught on the first edge after reset release
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			boot_seen <= 1'b0;
			boot_en   <= 1'b0;
		end else if (!boot_seen) begin
			boot_seen <= 1'b1;
			boot_en   <= BOOT_LOADER_MODE;
		end
	end

	// previous CAN level for rising edge detection
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			can_q <= 1'b1;
		end else begin
			can_q <= CAN_RECEIVE_PIN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer: measure, divide, check, load
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state      <= ST_WATCH;
			run_count  <= '0;
			count_capt <= '0;
			rem        <= '0;
			rises      <= '0;
			baud_prescaler        <= '0;
			quanta     <= '0;
		end else if (restart || fault_set) begin
			state <= ST_WATCH;
		end else begin
			case (state)
				ST_WATCH: begin
					// CAN is polled ahead of the UART line
					if (boot_en && ctrl[CTRL_ARM]) begin
						if (!CAN_RECEIVE_PIN) begin
							state     <= ST_CAN;
							run_count <= CNT_W'(1);
							rises     <= '0;
						end else if (!UART_RECEIVE_LINE) begin
							state     <= ST_UART;
							run_count <= CNT_W'(1);
						end
					end
				end
				ST_UART: begin
					// low run timed until the line returns high; the sequencer then halts
					if (UART_RECEIVE_LINE) begin
						state      <= ST_HALT;
						count_capt <= run_count;
					end else begin
						run_count <= run_count + 1'b1;
					end
				end
				ST_CAN: begin
					run_count <= run_count + 1'b1;
					// each recessive stuff bit ends a five-dominant run
					if (can_rise) begin
						rises <= rises + 1'b1;
						if (rises == STUFF_RISES - 3'h1) begin
							// count stops on the sampling edge: one tick of latency,
							// well inside the tolerated uncertainty
							state      <= ST_BRP;
							count_capt <= run_count;
							rem        <= run_count;
							baud_prescaler        <= '0;
						end
					end
				end
				ST_BRP: begin
					// repeated subtraction: one step per cycle, at most 64
					if (rem >= CNT_W'(BRP_STEP)) begin
						rem <= rem - CNT_W'(BRP_STEP);
						baud_prescaler <= baud_prescaler + 1'b1;
					end else begin
						state  <= ST_QUANTA;
						rem    <= count_capt;
						quanta <= '0;
					end
				end
				ST_QUANTA: begin
					if (rem >= divisor) begin
						rem    <= rem - divisor;
						quanta <= quanta + 1'b1;
					end else begin
						if ({rem, 1'b0} > {1'b0, divisor}) begin
							quanta <= quanta + 1'b1;
						end
						state <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					state <= ST_LOAD; // out of range already left via fault_set
				end
				ST_LOAD: begin
					if (drain && load_count == LOAD_BYTES - 8'h01) begin
						state <= ST_DONE;
					end
				end
				ST_HALT, ST_DONE: begin
					state <= state; // left only by restart
				end
				default: begin
					state <= ST_WATCH;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bit timing handed to the CAN controller
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			CAN_CONFIGURED        <= 1'b0;
			BAUD_PRESCALER        <= '0;
			SEGMENT_BEFORE_SAMPLE <= '0;
			SEGMENT_AFTER_SAMPLE  <= '0;
			JUMP_WIDTH            <= '0;
		end else if (restart) begin
			CAN_CONFIGURED <= 1'b0;
		end else if (state == ST_CHECK && q_ok) begin
			CAN_CONFIGURED        <= 1'b1;
			BAUD_PRESCALER        <= baud_prescaler;
			SEGMENT_AFTER_SAMPLE  <= seg_after(quanta);
			SEGMENT_BEFORE_SAMPLE <= quanta - 5'h01 - 5'(seg_after(quanta));
			JUMP_WIDTH            <= SJW_TQ;
		end
	end

	// transmit pin: recessive latch set before the controller drives it
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			CAN_TRANSMIT_PIN_O    <= 1'b1;
			CAN_TRANSMIT_PIN_OE_N <= 1'b1;
		end else if (restart) begin
			CAN_TRANSMIT_PIN_O    <= 1'b1;
			CAN_TRANSMIT_PIN_OE_N <= 1'b1;
		end else if (state == ST_CHECK && q_ok) begin
			CAN_TRANSMIT_PIN_O    <= 1'b1;
			CAN_TRANSMIT_PIN_OE_N <= 1'b0;
		end else begin
			CAN_TRANSMIT_PIN_O <= CAN_CONFIGURED ? CTRL_TXD : 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// acknowledge object: held ready, sent once on a matching remote frame
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ACK_SEND    <= 1'b0;
			ack_sent    <= 1'b0;
			ACK_ID_OUT  <= '0;
			ACK_DLC_OUT <= '0;
			ACK_DATA    <= '0;
		end else begin
			ACK_SEND <= 1'b0;
			if (restart) begin
				ack_sent <= 1'b0;
			end else if (state == ST_CHECK && q_ok) begin
				ACK_ID_OUT  <= ACK_ID;
				ACK_DLC_OUT <= ACK_DLC;
				ACK_DATA    <= {CHIP_IDENT[15:8], CHIP_IDENT[7:0], ACK_BYTE0};
			end else if (CAN_CONFIGURED && !ack_sent && MSG_VALID && MSG_READY
					&& MSG_REMOTE && MSG_ID == ACK_ID) begin
				ACK_SEND <= 1'b1;
				ack_sent <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive object: exact identifier match, length ignored, first byte kept
	assign boot_hit      = ((MSG_ID ^ BOOT_ID) & BOOT_MASK) == 11'h000;
	assign fifo_in_valid = state == ST_LOAD && MSG_VALID && !MSG_REMOTE && boot_hit;
	assign drain         = fifo_out_valid && state == ST_LOAD && !ctrl[CTRL_HOLD];

	cba_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (CLK_SYS),
		.rst_n     (RESETN),
		.in_valid  (fifo_in_valid),
		.in_ready  (MSG_READY),
		.in_data   (MSG_BYTE),
		.out_valid (fifo_out_valid),
		.out_ready (drain),
		.out_data  (fifo_data)
	);

	cba_mem #(.AW(7), .DW(8)) u_mem (
		.clk     (CLK_SYS),
		.wr_en   (drain),
		.wr_addr (load_count[6:0]),
		.wr_data (fifo_data),
		.rd_addr (PADDR[8:2]),
		.rd_data (mem_rdata)
	);

	// loaded byte counter
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			load_count <= '0;
		end else if (restart) begin
			load_count <= '0;
		end else if (drain) begin
			load_count <= load_count + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control bits and sticky fault: a fault in the clearing cycle wins
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ctrl  <= CTRL_RST;
			fault <= 1'b0;
		end else begin
			if (apb_wr && PADDR == OFS_CTRL) begin
				ctrl <= PWDATA[1:0];
			end
			if (fault_set) begin
				fault <= 1'b1;
			end else if (apb_wr && PADDR == OFS_STATUS && PWDATA[STS_FAULT]) begin
				fault <= 1'b0;
			end
		end
	end

	// read decode
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		if (PADDR == OFS_CTRL) begin
			rd_val = {30'h0, ctrl};
		end else if (PADDR == OFS_STATUS) begin
			rd_val = {22'h0, boot_en, fault, 2'h0, ack_sent, CAN_CONFIGURED, state};
		end else if (PADDR == OFS_COUNT) begin
			rd_val = 32'(count_capt);
		end else if (PADDR == OFS_TIMING) begin
			rd_val = {3'h0, quanta, 4'h0, SEGMENT_AFTER_SAMPLE, 3'h0, SEGMENT_BEFORE_SAMPLE,
				JUMP_WIDTH, BAUD_PRESCALER};
		end else if (PADDR == OFS_LOAD) begin
			rd_val = {24'h0, load_count};
		end else if (PADDR == OFS_ACKDAT) begin
			rd_val = {8'h0, ACK_DATA};
		end else if (PADDR[11:9] == OFS_MEM[11:9] && PADDR[1:0] == 2'h0) begin
			rd_val = {24'h0, mem_rdata};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// APB answer: one wait state, memory data registered in time
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			PREADY  <= 1'b0;
			PRDATA  <= '0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= apb_acc;
			PSLVERR <= apb_acc & ~rd_hit;
			if (apb_acc && !PWRITE) begin
				PRDATA <= rd_val;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	chk_both_lines: assert property (state == ST_WATCH && boot_en && ctrl[CTRL_ARM]
		&& !restart && (!CAN_RECEIVE_PIN || !UART_RECEIVE_LINE) |=> state != ST_WATCH)
		else $error("low receive line not picked up");
	chk_stop_count: assert property (state == ST_CAN && can_rise && rises == 3'h4
		&& !fault_set && !restart |=> state == ST_BRP && count_capt == $past(run_count))
		else $error("span not captured at fifth stuff bit");
	chk_brp_div: assert property (state == ST_BRP ##1 state == ST_QUANTA
		|-> baud_prescaler == 6'(count_capt / CNT_W'(BRP_STEP)))
		else $error("prescaler is not count over 1451");
	chk_quanta_round: assert property ($rose(CAN_CONFIGURED) |-> quanta == 5'(
		count_capt / divisor + CNT_W'({count_capt % divisor, 1'b0} > {1'b0, divisor})))
		else $error("quanta not rounded from count");
	chk_tq_range: assert property (CAN_CONFIGURED |-> SEGMENT_BEFORE_SAMPLE
		+ 5'(SEGMENT_AFTER_SAMPLE) + 5'h01 inside {[TQ_MIN:TQ_MAX]})
		else $error("bit length out of range");
	chk_sample_point: assert property (CAN_CONFIGURED |->
		10 * (1 + int'(SEGMENT_BEFORE_SAMPLE)) >= 7 * int'(quanta)
		&& 10 * (1 + int'(SEGMENT_BEFORE_SAMPLE)) <= 8 * int'(quanta))
		else $error("sample point outside 70 to 80 percent");
	chk_sjw_fixed: assert property (CAN_CONFIGURED |-> JUMP_WIDTH == 2'h2)
		else $error("jump width not two quanta");
	chk_pin_recessive: assert property ($fell(CAN_TRANSMIT_PIN_OE_N)
		|-> CAN_TRANSMIT_PIN_O && $rose(CAN_CONFIGURED))
		else $error("pin enabled without recessive latch");
	chk_ack_once: assert property (ACK_SEND |=> !ACK_SEND [*8])
		else $error("acknowledge sent twice");
	chk_ack_remote: assert property (ACK_SEND |-> $past(MSG_VALID && MSG_REMOTE
		&& MSG_ID == ACK_ID))
		else $error("acknowledge without remote request");
	chk_boot_filter: assert property (fifo_in_valid |-> MSG_ID == 11'h005 && !MSG_REMOTE)
		else $error("wrong message taken as boot byte");
	chk_load_limit: assert property (state == ST_DONE |-> load_count == 8'h80)
		else $error("load stopped at wrong byte count");
	chk_overflow: assert property (state == ST_CAN && (&run_count) |=> state == ST_WATCH
		&& fault)
		else $error("overflow not discarded");

	cov_configured: cover property ($rose(CAN_CONFIGURED));
	cov_ack_sent: cover property (ACK_SEND);
	cov_load_done: cover property (state == ST_LOAD ##1 state == ST_DONE);
	cov_fault: cover property ($rose(fault));
endmodule : cba_autobaud

// ---- dv/cba_host.sv ----
// host node model: zero frame on the can line and messages to the receive path
`timescale 1ns/10ps
module cba_host (
	input  wire logic        CLK_SYS,
	output logic             can_rx,
	output logic             msg_valid,
	input  wire logic        msg_ready,
	output logic      [10:0] msg_id,
	output logic             msg_remote,
	output logic      [7:0]  msg_byte
);
	// idle bus is recessive, driven high by the model
	initial begin
		can_rx = 1'b1;
		msg_valid = 1'b0;
		msg_id = 11'h000;
		msg_remote = 1'b0;
		msg_byte = 8'h00;
	end
	////////////////
	// zero frame: six runs of five dominant bits, each followed by a stuff bit; x stretches the fifth run
	task automatic zero_frame(input int bt, input int x);
		@(posedge CLK_SYS);
		for (int g = 0; g < 6; g++) begin
			can_rx <= 1'b0;
			repeat (5 * bt + ((g == 4) ? x : 0)) @(posedge CLK_SYS);
			can_rx <= 1'b1;
			repeat (bt) @(posedge CLK_SYS);
		end
	endtask : zero_frame
	// one message held until taken; identifier and byte scrambled once released, remote flag kept
	task automatic send(input logic [10:0] id, input logic rem, input logic [7:0] b);
		@(posedge CLK_SYS);
		msg_valid <= 1'b1;
		msg_id <= id;
		msg_remote <= rem;
		msg_byte <= b;
		do @(posedge CLK_SYS); while (msg_ready !== 1'b1);
		msg_valid <= 1'b0;
		msg_id <= ~id;
		msg_byte <= ~b;
	endtask : send
endmodule : cba_host

// ---- dv/testbench.sv ----
// self-checking bench for the can boot autobaud block
`timescale 1ns/10ps
module testbench;
	import cba_pkg::*;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ctrl_txd = 1'b1, uart_rx = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, er, can_rx, msg_valid, msg_ready, msg_remote;
	logic        ack_send, can_conf, tx_o, tx_oe_n;
	logic [10:0] msg_id, ack_id;
	logic [7:0]  msg_byte;
	logic [3:0]  ack_dlc, seg_a;
	logic [23:0] ack_data;
	logic [5:0]  baud_prescaler;
	logic [4:0]  seg_b;
	logic [1:0]  sjw;
	logic [15:0] lfsr_st = 16'h3FA7;
	logic [7:0]  exp_mem [128];
	int          err_count = 0, num_checks = 0, n;
	int          bts [5] = '{5, 33, 60, 20, 20};
	int          xs [5] = '{0, 0, 0, 30, 6};
	always #2.5 clk_sys = ~clk_sys;
	// identity and marker values are arbitrary
	cba_autobaud #(.ACK_BYTE0(8'h5A), .CHIP_IDENT(16'h0C3E)) i_dut (
		.CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.BOOT_LOADER_MODE(1'b1), .UART_RECEIVE_LINE(uart_rx), .CAN_RECEIVE_PIN(can_rx),
		.CAN_TRANSMIT_PIN_O(tx_o), .CAN_TRANSMIT_PIN_OE_N(tx_oe_n), .CTRL_TXD(ctrl_txd),
		.MSG_VALID(msg_valid), .MSG_READY(msg_ready), .MSG_ID(msg_id), .MSG_REMOTE(msg_remote),
		.MSG_BYTE(msg_byte), .ACK_SEND(ack_send), .ACK_ID_OUT(ack_id), .ACK_DLC_OUT(ack_dlc),
		.ACK_DATA(ack_data), .CAN_CONFIGURED(can_conf), .BAUD_PRESCALER(baud_prescaler),
		.SEGMENT_BEFORE_SAMPLE(seg_b), .SEGMENT_AFTER_SAMPLE(seg_a), .JUMP_WIDTH(sjw));
	cba_host i_host (.CLK_SYS(clk_sys), .can_rx(can_rx), .msg_valid(msg_valid),
		.msg_ready(msg_ready), .msg_id(msg_id), .msg_remote(msg_remote), .msg_byte(msg_byte));
	////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [7:0] lfsr();
		lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
		return lfsr_st[7:0];
	endfunction : lfsr
	// restart, send the zero frame up to three times until answered, compare against the reference arithmetic
	task automatic frame(input int bt, input int x);
		int cnt, p, dv, q, sa;
		cnt = FRAME_BITS * bt + x;
		p = cnt / BRP_STEP;
		dv = PT_SCALE * (p + 1);
		q = cnt / dv + ((2 * (cnt % dv) > dv) ? 1 : 0);
		sa = (q + 4) / 5;
		// restart disarmed: the first zero frame goes unanswered, so the host repeats it
		apb(1'b1, OFS_CTRL, 32'h0000_0004);
		i_host.zero_frame(bt, x);
		chk("unanswered", tx_oe_n, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		repeat (4) @(posedge clk_sys);
		for (int t = 0; t < 2 && tx_oe_n === 1'b1; t++) i_host.zero_frame(bt, x);
		for (int i = 0; i < 200 && can_conf !== 1'b1; i++) @(posedge clk_sys);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		if (q < 8 || q > 25) begin
			chk("fault", {rd[STS_FAULT], can_conf}, 2'b10);
			apb(1'b1, OFS_STATUS, 32'h0000_0100);
		end else begin
			chk("pin_out", {tx_oe_n, tx_o}, 2'b01);
			chk("outs", {baud_prescaler, sjw, seg_b, seg_a}, {p[5:0], SJW_TQ, 5'(q - 1 - sa), 4'(sa)});
			apb(1'b0, OFS_TIMING, 32'h0000_0000);
			chk("timing", rd, p + (2 << 6) + ((q - 1 - sa) << 8) + (sa << 16) + (q << 24));
			apb(1'b0, OFS_COUNT, 32'h0000_0000);
			chk("count", rd, cnt);
		end
	endtask : frame
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	////////////////
	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk("reset_pins", {tx_o, tx_oe_n, can_conf, msg_ready}, 4'b1101);
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("ctrl_reset", rd, CTRL_RST);
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk("unmapped", er, 1'b1);
		// uart low run of 37 cycles is timed, then the block parks in the uart halt state
		uart_rx <= 1'b0;
		repeat (37) @(posedge clk_sys);
		uart_rx <= 1'b1;
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("uart_halt", rd[3:0], 4'h2);
		apb(1'b0, OFS_COUNT, 32'h0000_0000);
		chk("uart_count", rd, 32'h0000_0025);
		$display("test reset done");
		for (int k = 0; k < 5; k++) frame(bts[k], xs[k]);
		ctrl_txd <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("pin_follow", tx_o, 1'b0);
		ctrl_txd <= 1'b1;
		$display("test frames done");
		// second remote request must not send again
		for (int k = 0; k < 2; k++) begin
			i_host.send(ACK_ID, 1'b1, 8'h00);
			n = 0;
			repeat (6) @(posedge clk_sys) n += (ack_send === 1'b1);
			chk("ack_pulses", n, (k == 0) ? 1 : 0);
		end
		chk("ack_id", {ack_id, ack_dlc}, {ACK_ID, ACK_DLC});
		chk("ack_data", ack_data, 24'h0C_3E5A);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("status_bits", {rd[STS_BOOT], rd[STS_ACK], rd[STS_CONF]}, 3'b111);
		$display("test ack done");
		i_host.send(11'h006, 1'b0, 8'h11);
		i_host.send(BOOT_ID, 1'b1, 8'h22);
		apb(1'b1, OFS_CTRL, 32'h0000_0003);
		for (int i = 0; i < 128; i++) begin
			if (i == 8) begin
				@(posedge clk_sys);
				chk("fifo_full", msg_ready, 1'b0);
				apb(1'b1, OFS_CTRL, 32'h0000_0001);
			end
			exp_mem[i] = lfsr();
			i_host.send(BOOT_ID, 1'b0, exp_mem[i]);
		end
		repeat (20) @(posedge clk_sys);
		apb(1'b0, OFS_LOAD, 32'h0000_0000);
		chk("loaded", rd, LOAD_BYTES);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("state", rd[3:0], 4'h8);
		for (int i = 0; i < 128; i += 9) begin
			apb(1'b0, OFS_MEM + 12'(4 * i), 32'h0000_0000);
			chk("mem", rd, exp_mem[i]);
		end
		$display("test load done");
		summarize();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (40000) @(posedge clk_sys);
		err_count++;
		summarize();
	end
endmodule : testbench
